// file: logic/static_mem_ctrl.sv
/*
 * External static memory controller: an APB register slave for per-bank
 * setup and a simple 32-bit system request port mapped onto eight
 * external banks with wait states, turnaround cycles and data width
 * conversion.
 * Assumes the system port holds its request until sys_ready, and that
 * the data bus pads resolve ext_data_out / ext_data_oe outside.
 */
// The APB register port and the register addresses were chosen for this implementation.
// Function
// [R1] Eight independently configured banks, 16 MB each.
// [R2] Per-bank device type steers access timing.
// [R3] Turnaround idle cycles programmable one to sixteen.
// [R4] Idle cycles between read then write same bank.
// [R5] SRAM read and write waits up to 32.
// [R6] Burst ROM first and subsequent read waits.
// [R7] Page and burst reads without memory clock.
// [R8] Burst mode enabled per bank.
// [R9] Write protection per bank.
// [R10] External width 8, 16 or 32 bits.
// [R11] Byte lanes during reads programmable per bank.
// [R12] One bank select per bank, programmable polarity.
// [R13] External only when address top bits 010.
// [R14] Address bits 28 to 26 select bank.
// [R15] Address bits 25 and 24 ignored.
// [R16] Address bits 23 to 0 drive external address.
// [R17] Write and read strobes active low.
// [R18] Four byte lane selects on 32-bit bus.
// [R19] Protected write produces no external strobe.
// [R20] System transfer waits until external access completes.
`timescale 1ns/10ps
`include "smc_params.svh"

module static_mem_ctrl
    import smc_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    // APB register slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // System access port
    input  wire logic        sys_req,
    input  wire logic        sys_write,
    input  wire logic [31:0] sys_addr,
    input  wire logic [31:0] sys_wdata,
    input  wire logic [3:0]  sys_be,
    output logic      [31:0] sys_rdata,
    output logic             sys_ready,
    output logic             sys_err,
    // External static memory bus
    output logic      [7:0]  bank_select_out,
    output logic      [3:0]  byte_lane_select,
    output logic             write_strobe_n,
    output logic             read_strobe_n,
    output logic      [23:0] ext_address_out,
    input  wire logic [31:0] ext_data_in,
    output logic      [31:0] ext_data_out,
    output logic             ext_data_oe
);

    logic [3:0]  turnaround_idle_cycles [0:7];
    logic [4:0]  wst_rd  [0:7];
    logic [4:0]  wst_wr  [0:7];
    logic [7:0]  cfg     [0:7];

    logic [31:0] din_s1;
    logic [31:0] din_s2;

    smc_state_t  state;
    logic [2:0]  bank;
    logic [23:0] base_loc;
    logic [1:0]  beat;
    logic [1:0]  last_beat;
    logic [4:0]  cnt;
    logic        cur_write;
    logic        last_read;
    logic [2:0]  last_bank;
    logic        burst_run;
    logic [31:0] rd_acc;

    logic [2:0]  req_bank;
    logic [7:0]  bcfg;
    smc_width_t  bwidth;
    smc_dev_t    bdev;
    logic        req_ext;
    logic        req_blocked;
    logic [1:0]  next_last_beat;
    logic [23:0] beat_loc;
    logic [4:0]  acc_wait;

    // APB slave: always ready, errors on unmapped offsets.
    logic [2:0] apb_bank;
    logic [3:0] apb_reg;
    logic       apb_hit;
    assign apb_bank = paddr[7:5];
    assign apb_reg  = paddr[5-1:2] == 3'h0 ? `SMC_REG_IDLE :
                      {1'b0, paddr[4:2]};
    assign apb_hit  = (paddr[31:8] == 24'h000000) && (paddr[1:0] == 2'h0) &&
                      (apb_reg <= `SMC_REG_STAT);
    assign pready   = 1'b1;
    assign pslverr  = psel && penable && !apb_hit;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            for (int i = 0; i < `SMC_NUM_BANKS; i++) begin
                turnaround_idle_cycles[i] <= `SMC_IDLE_RST;
                wst_rd[i] <= `SMC_WST_RST;
                wst_wr[i] <= `SMC_WST_RST;
                cfg[i]    <= `SMC_CFG_RST;
            end
        end else if (psel && penable && pwrite && apb_hit) begin
            case (apb_reg)
                `SMC_REG_IDLE:   turnaround_idle_cycles[apb_bank] <= pwdata[3:0]; // see [R3]
                `SMC_REG_WST_RD: wst_rd[apb_bank] <= pwdata[4:0]; // see [R5] see [R6]
                `SMC_REG_WST_WR: wst_wr[apb_bank] <= pwdata[4:0]; // see [R5] see [R6]
                `SMC_REG_CFG:    cfg[apb_bank]    <= pwdata[7:0]; // see [R1] see [R2]
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            case (apb_reg)
                `SMC_REG_IDLE:   prdata <= {28'h0, turnaround_idle_cycles[apb_bank]};
                `SMC_REG_WST_RD: prdata <= {27'h0, wst_rd[apb_bank]};
                `SMC_REG_WST_WR: prdata <= {27'h0, wst_wr[apb_bank]};
                `SMC_REG_CFG:    prdata <= {24'h0, cfg[apb_bank]};
                `SMC_REG_STAT:   prdata <= {24'h0, 3'h0, state};
                default:         prdata <= 32'h0000_0000;
            endcase
        end
    end

    // The external data bus is an asynchronous pin input.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            din_s1 <= 32'h0000_0000;
            din_s2 <= 32'h0000_0000;
        end else begin
            din_s1 <= ext_data_in;
            din_s2 <= din_s1;
        end
    end

    // Request decode. Bits 25 and 24 are never looked at, so they alias.
    assign req_ext     = sys_addr[`SMC_BA_HI:`SMC_BA_LO] == `SMC_EXT_BASE; // see [R13] see [R15]
    assign req_bank    = sys_addr[`SMC_CS_HI:`SMC_CS_LO];                   // see [R14]
    assign bcfg        = cfg[bank];
    assign bwidth      = smc_width_t'(bcfg[`SMC_CFG_WIDTH_LO +: 2]);
    assign bdev        = smc_dev_t'(bcfg[`SMC_CFG_TYPE_LO +: 2]);
    assign req_blocked = sys_write && (cfg[req_bank][`SMC_CFG_WPROT] ||
                         smc_dev_t'(cfg[req_bank][`SMC_CFG_TYPE_LO +: 2]) != SMC_DEV_SRAM &&
                         smc_dev_t'(cfg[req_bank][`SMC_CFG_TYPE_LO +: 2]) != SMC_DEV_IO); // see [R9] see [R19]

    always_comb begin
        case (smc_width_t'(cfg[req_bank][`SMC_CFG_WIDTH_LO +: 2]))
            SMC_W8:  next_last_beat = 2'h3;
            SMC_W16: next_last_beat = 2'h1;
            default: next_last_beat = 2'h0;
        endcase
    end

    // Per-beat location and wait: narrow banks step through the word.
    always_comb begin
        case (bwidth)
            SMC_W8:  beat_loc = {base_loc[23:2], beat};
            SMC_W16: beat_loc = {base_loc[23:2], beat[0], 1'b0};
            default: beat_loc = base_loc;
        endcase
        if (cur_write) begin
            acc_wait = wst_wr[bank];
        end else if (bdev == SMC_DEV_BROM && bcfg[`SMC_CFG_BURST] && burst_run) begin
            acc_wait = wst_wr[bank];                  // see [R6] see [R7] see [R8]
        end else begin
            acc_wait = wst_rd[bank];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state     <= SMC_ST_IDLE;
            bank      <= 3'h0;
            base_loc  <= 24'h000000;
            beat      <= 2'h0;
            last_beat <= 2'h0;
            cnt       <= 5'h00;
            cur_write <= 1'b0;
            last_read <= 1'b0;
            last_bank <= 3'h0;
            burst_run <= 1'b0;
            rd_acc    <= 32'h0000_0000;
            sys_rdata <= 32'h0000_0000;
            sys_ready <= 1'b0;
            sys_err   <= 1'b0;
        end else begin
            sys_ready <= 1'b0;
            sys_err   <= 1'b0;
            case (state)
                SMC_ST_IDLE: begin
                    if (sys_req && !sys_ready) begin
                        if (!req_ext || req_blocked) begin
                            sys_ready <= 1'b1;               // see [R19]
                            sys_err   <= 1'b1;
                        end else begin
                            bank      <= req_bank;
                            base_loc  <= sys_addr[`SMC_LOC_HI:0]; // see [R16]
                            cur_write <= sys_write;
                            beat      <= 2'h0;
                            last_beat <= next_last_beat;        // see [R10]
                            burst_run <= 1'b0;
                            cnt       <= {1'b0, turnaround_idle_cycles[req_bank]};
                            if (last_read && sys_write && last_bank == req_bank) begin
                                state <= SMC_ST_TURN;           // see [R4]
                            end else begin
                                cnt   <= 5'h00;
                                state <= SMC_ST_NEXT;
                            end
                        end
                    end
                end
                SMC_ST_TURN: begin
                    // Field value n gives n+1 idle cycles.
                    if (cnt == 5'h00) begin
                        state <= SMC_ST_NEXT;                   // see [R3]
                    end else begin
                        cnt <= cnt - 5'h01;
                    end
                end
                SMC_ST_NEXT: begin
                    cnt   <= acc_wait;
                    state <= SMC_ST_ACC;
                end
                SMC_ST_ACC: begin
                    if (cnt != 5'h00) begin
                        cnt <= cnt - 5'h01;                     // see [R5] see [R20]
                    end else begin
                        case (bwidth)
                            SMC_W8:  rd_acc[beat*8 +: 8]       <= din_s2[7:0];
                            SMC_W16: rd_acc[beat[0]*16 +: 16]  <= din_s2[15:0];
                            default: rd_acc                    <= din_s2;
                        endcase
                        burst_run <= 1'b1;
                        if (beat == last_beat) begin
                            state <= SMC_ST_DONE;
                        end else begin
                            beat  <= beat + 2'h1;
                            state <= SMC_ST_NEXT;
                        end
                    end
                end
                SMC_ST_DONE: begin
                    sys_rdata <= rd_acc;
                    sys_ready <= 1'b1;                          // see [R20]
                    last_read <= !cur_write;
                    last_bank <= bank;
                    state     <= SMC_ST_IDLE;
                end
                default: state <= SMC_ST_IDLE;
            endcase
        end
    end

    // External pin drive, all registered.
    logic       in_acc;
    logic [3:0] lanes;
    assign in_acc = state == SMC_ST_ACC || state == SMC_ST_NEXT;

    always_comb begin
        case (bwidth)
            SMC_W8:  lanes = {3'h0, sys_be[beat]};
            SMC_W16: lanes = {2'h0, sys_be[{beat[0], 1'b1}], sys_be[{beat[0], 1'b0}]};
            default: lanes = sys_be;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            bank_select_out  <= 8'h00;
            byte_lane_select <= 4'h0;
            write_strobe_n   <= 1'b1;
            read_strobe_n    <= 1'b1;
            ext_address_out  <= 24'h000000;
            ext_data_out     <= 32'h0000_0000;
            ext_data_oe      <= 1'b0;
        end else begin
            for (int i = 0; i < `SMC_NUM_BANKS; i++) begin
                bank_select_out[i] <= cfg[i][`SMC_CFG_CSPOL] ^
                                      ~(in_acc && bank == 3'(i));  // see [R12]
            end
            ext_address_out <= beat_loc;                           // see [R16]
            write_strobe_n  <= !(in_acc && cur_write);             // see [R17] see [R19]
            read_strobe_n   <= !(in_acc && !cur_write);            // see [R17] see [R7]
            ext_data_oe     <= in_acc && cur_write;
            case (bwidth)
                SMC_W8:  ext_data_out <= {24'h0, sys_wdata[beat*8 +: 8]};
                SMC_W16: ext_data_out <= {16'h0, sys_wdata[beat[0]*16 +: 16]};
                default: ext_data_out <= sys_wdata;                // see [R10]
            endcase
            if (in_acc && (cur_write || bcfg[`SMC_CFG_RDLANE])) begin
                byte_lane_select <= lanes;                         // see [R11] see [R18]
            end else begin
                byte_lane_select <= 4'h0;
            end
        end
    end

endmodule : static_mem_ctrl

// file: logic/smc_params.svh
/*
 * Constants of the external static memory controller: register offsets,
 * field positions, reset values and address decode fields.
 * Assumes inclusion by bare name from the design module and the bench top.
 */
`ifndef SMC_PARAMS_SVH
`define SMC_PARAMS_SVH

`define SMC_NUM_BANKS        8
`define SMC_EXT_BASE         3'h2
`define SMC_BA_HI            31
`define SMC_BA_LO            29
`define SMC_CS_HI            28
`define SMC_CS_LO            26
`define SMC_LOC_HI           23

`define SMC_REG_IDLE         4'h0
`define SMC_REG_WST_RD       4'h1
`define SMC_REG_WST_WR       4'h2
`define SMC_REG_CFG          4'h3
`define SMC_REG_STAT         4'h4
`define SMC_BANK_STRIDE_SH   5

`define SMC_CFG_WIDTH_LO     0
`define SMC_CFG_TYPE_LO      2
`define SMC_CFG_BURST        4
`define SMC_CFG_WPROT        5
`define SMC_CFG_RDLANE       6
`define SMC_CFG_CSPOL        7

`define SMC_IDLE_RST         4'h0
`define SMC_WST_RST          5'h1F
`define SMC_CFG_RST          8'h00

`endif

// file: logic/smc_pkg.sv
/*
 * Types shared by the external static memory controller.
 * Assumes smc_params.svh is reachable on the include path.
 */
package smc_pkg;
    typedef enum logic [1:0] {
        SMC_W8  = 2'h0,
        SMC_W16 = 2'h1,
        SMC_W32 = 2'h2
    } smc_width_t;

    typedef enum logic [1:0] {
        SMC_DEV_SRAM  = 2'h0,
        SMC_DEV_ROM   = 2'h1,
        SMC_DEV_BROM  = 2'h2,
        SMC_DEV_IO    = 2'h3
    } smc_dev_t;

    typedef enum logic [4:0] {
        SMC_ST_IDLE = 5'h01,
        SMC_ST_TURN = 5'h02,
        SMC_ST_ACC  = 5'h04,
        SMC_ST_NEXT = 5'h08,
        SMC_ST_DONE = 5'h10
    } smc_state_t;
endpackage : smc_pkg

// file: verification/smc_checker.sv
/* Port checker for the static memory controller.
   Assumes a bind from the bench top onto the design's ports. */
`timescale 1ns/10ps
module smc_checker (
    // Clock, reset and system port
    input wire logic        sys_clk,
    input wire logic        rst_n,
    input wire logic        sys_req,
    input wire logic [31:0] sys_addr,
    input wire logic        sys_ready,
    input wire logic        sys_err,
    // External bus
    input wire logic [7:0]  bank_select_out,
    input wire logic        write_strobe_n,
    input wire logic        read_strobe_n,
    input wire logic [23:0] ext_address_out,
    input wire logic [31:0] ext_data_out,
    input wire logic        ext_data_oe
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    property p_one_strobe; !(!write_strobe_n && !read_strobe_n); endproperty
    a_one_strobe: assert property (p_one_strobe) else $error("both strobes low");
    property p_wr_drive; !write_strobe_n |-> ext_data_oe; endproperty
    a_wr_drive: assert property (p_wr_drive) else $error("write without data drive");
    property p_ext_only; $rose(sys_req) && sys_addr[31:29] != 3'h2 |-> (write_strobe_n && read_strobe_n) [*3];
    endproperty
    a_ext_only: assert property (p_ext_only) else $error("strobe for non-external address");
    property p_ext_err; $rose(sys_req) && sys_addr[31:29] != 3'h2 |-> ##[1:3] sys_ready && sys_err; endproperty
    a_ext_err: assert property (p_ext_err) else $error("non-external access not refused");
    property p_err_quiet; sys_err |-> write_strobe_n && read_strobe_n && $past(write_strobe_n); endproperty
    a_err_quiet: assert property (p_err_quiet) else $error("strobe on refused access");
    property p_ready_pulse; sys_ready |=> !sys_ready; endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");
    property p_strobe_req; $fell(read_strobe_n) || $fell(write_strobe_n) |-> sys_req; endproperty
    a_strobe_req: assert property (p_strobe_req) else $error("strobe without request");
    property p_hold; !write_strobe_n && !$past(write_strobe_n) |->
        $stable(ext_address_out) && $stable(ext_data_out) && $stable(bank_select_out); endproperty
    a_hold: assert property (p_hold) else $error("bus moved under write strobe");
    property p_loc; $fell(write_strobe_n) |-> ext_address_out[23:16] == sys_addr[23:16]; endproperty
    a_loc: assert property (p_loc) else $error("external address differs");
endmodule : smc_checker

// file: verification/smc_ext_mem_model.sv
/* Behavioural external static memory on the controller's far side.
   Assumes 32-bit parts decoded on address bits 9 to 2. */
`timescale 1ns/10ps
module smc_ext_mem_model (
    // Strobes and address
    input wire logic        sys_clk,
    input wire logic [3:0]  byte_lane_select,
    input wire logic        write_strobe_n,
    input wire logic        read_strobe_n,
    input wire logic [23:0] ext_address_out,
    // Data bus
    input wire logic [31:0] ext_data_out,
    input wire logic        ext_data_oe,
    output logic     [31:0] ext_data_in
);
    logic [31:0] mem [256];
    logic [31:0] last;
    initial begin
        foreach (mem[i]) mem[i] = 32'h0;
        last = 32'h0;
    end
    always @(posedge sys_clk) begin
        if (!write_strobe_n && ext_data_oe) begin
            for (int i = 0; i < 4; i++) begin
                if (byte_lane_select[i]) mem[ext_address_out[9:2]][8*i+:8] <= ext_data_out[8*i+:8];
            end
        end
        if (!read_strobe_n) last <= ext_data_in;
    end
    // A released bus shows the inverse of the last word, never a held copy.
    assign ext_data_in = (!read_strobe_n && !ext_data_oe) ? mem[ext_address_out[9:2]] : ~last;
endmodule : smc_ext_mem_model

// file: verification/static_mem_ctrl_tb_top.sv
/* Bench top: APB setup, random system traffic and refused accesses.
   Assumes the checker and memory model are compiled first. */
`timescale 1ns/10ps
`include "smc_params.svh"
module static_mem_ctrl_tb_top import smc_pkg::*; ;
    logic        sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, e;
    logic        sys_req, sys_write, sys_ready, sys_err, write_strobe_n, read_strobe_n, ext_data_oe;
    logic [31:0] paddr, pwdata, prdata, sys_addr, sys_wdata, sys_rdata, ext_data_in, ext_data_out, r, a, d;
    logic [3:0]  sys_be, byte_lane_select, seen_lane, be, idl [8];
    logic [7:0]  bank_select_out, seen_sel, pol, rl;
    logic [23:0] ext_address_out, seen_adr;
    logic [4:0]  rdw [8], wrw [8];
    logic [2:0]  b, lastb;
    logic [31:0] shadow [256];
    int          n_errors, checked, seed, lat;
    static_mem_ctrl dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sys_req(sys_req), .sys_write(sys_write), .sys_addr(sys_addr), .sys_wdata(sys_wdata),
        .sys_be(sys_be), .sys_rdata(sys_rdata), .sys_ready(sys_ready), .sys_err(sys_err),
        .bank_select_out(bank_select_out), .byte_lane_select(byte_lane_select),
        .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n), .ext_address_out(ext_address_out),
        .ext_data_in(ext_data_in), .ext_data_out(ext_data_out), .ext_data_oe(ext_data_oe));
    smc_ext_mem_model mem (
        .sys_clk(sys_clk), .byte_lane_select(byte_lane_select), .write_strobe_n(write_strobe_n),
        .read_strobe_n(read_strobe_n), .ext_address_out(ext_address_out),
        .ext_data_out(ext_data_out), .ext_data_oe(ext_data_oe), .ext_data_in(ext_data_in));
    initial begin
        sys_clk = 1'h0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_errors++;
        complete_run();
    end
    always @(posedge sys_clk) begin
        if (!read_strobe_n) seen_lane = seen_lane | byte_lane_select;
        if (!read_strobe_n || !write_strobe_n) begin
            seen_sel = bank_select_out;
            seen_adr = ext_address_out;
        end
    end
    task automatic complete_run();
        if (n_errors == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        checked++;
        if (got !== ex) begin
            $display("unexpected %s: expected %h, seen %h", nm, ex, got);
            n_errors++;
        end
    endtask : chk
    // Latency counts the edges from the request up to the edge at which sys_ready is seen.
    task automatic chk_lat(input int ex);
        checked++;
        if (lat != ex) begin
            $display("unexpected latency: expected %0d, seen %0d", ex, lat);
            n_errors++;
        end
    endtask : chk_lat
    task automatic apb(input logic w, input logic [31:0] ad, input logic [31:0] wd);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'h1;
        do @(posedge sys_clk); while (pready !== 1'h1);
        r = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge sys_clk);
    endtask : apb
    task automatic acc(input logic w, input logic [31:0] ad, input logic [31:0] wd, input logic [3:0] ben);
        seen_lane = 4'h0;
        sys_req <= 1'h1;
        sys_write <= w;
        sys_addr <= ad;
        sys_wdata <= wd;
        sys_be <= ben;
        lat = 0;
        do begin
            @(posedge sys_clk);
            lat++;
        end while (sys_ready !== 1'h1 && lat < 400);
        r = sys_rdata;
        e = sys_err;
        sys_req <= 1'h0;
        @(posedge sys_clk);
    endtask : acc
    function automatic logic [31:0] ra(input logic [2:0] bk, input logic [3:0] rg);
        return {24'h0, bk, rg[2:0], 2'h0};
    endfunction : ra
    function automatic logic [31:0] cfg(input logic [2:0] bk, input smc_width_t w, input smc_dev_t t,
                                        input logic wp, input logic bu);
        return {24'h0, pol[bk], rl[bk], wp, bu, t, w};
    endfunction : cfg
    initial begin
        seed = 32'h6F45;
        {rst_n, psel, penable, pwrite, sys_req, sys_write, sys_be} = 10'h0;
        {paddr, pwdata, sys_addr, sys_wdata} = 128'h0;
        foreach (shadow[i]) shadow[i] = 32'h0;
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'h1;
        @(posedge sys_clk);
        for (int k = 0; k < 8; k++) begin
            b = 3'(k);
            for (int g = 0; g < 5; g++) begin
                apb(1'h0, ra(b, 4'(g)), 32'h0);
                chk("reset value", (g == 1 || g == 2) ? 32'h1F : g == 4 ? 32'(SMC_ST_IDLE) : 32'h0, r);
            end
            apb(1'h1, ra(b, 4'h5), 32'hFFFF_FFFF);
            chk("unmapped error", 32'h1, 32'(e));
            pol[b] = 1'($random(seed));
            rl[b] = 1'($random(seed));
            rdw[b] = 5'h2 + 5'($random(seed) & 3);
            wrw[b] = 5'h2 + 5'($random(seed) & 3);
            idl[b] = 4'($random(seed));
            apb(1'h1, ra(b, `SMC_REG_IDLE), 32'(idl[b]));
            apb(1'h1, ra(b, `SMC_REG_WST_RD), 32'(rdw[b]));
            apb(1'h1, ra(b, `SMC_REG_WST_WR), 32'(wrw[b]));
            apb(1'h1, ra(b, `SMC_REG_CFG), cfg(b, SMC_W32, SMC_DEV_SRAM, 1'h0, 1'h0));
            apb(1'h0, ra(b, `SMC_REG_CFG), 32'h0);
            chk("config", cfg(b, SMC_W32, SMC_DEV_SRAM, 1'h0, 1'h0), r);
        end
        lastb = 3'h0;
        for (int i = 0; i < 24; i++) begin
            if (i[0]) b = 3'($random(seed));
            a = {3'h2, b, 2'($random(seed)), 14'h0, 8'($random(seed)), 2'h0};
            d = $random(seed);
            be = 4'($random(seed)) | 4'h1;
            acc(1'h1, a, d, be);
            chk("write error", 32'h0, 32'(e));
            chk_lat(wrw[b] + 5 + ((i > 0 && b == lastb) ? idl[b] + 1 : 0));
            chk("bank select", {24'h0, ~pol ^ (8'h01 << b)}, 32'(seen_sel));
            chk("address", 32'(a[23:0]), 32'(seen_adr));
            for (int j = 0; j < 4; j++) begin
                if (be[j]) shadow[a[9:2]][8*j+:8] = d[8*j+:8];
            end
            acc(1'h0, a, 32'h0, 4'hF);
            chk("read data", shadow[a[9:2]], r);
            chk("read lanes", rl[b] ? 32'hF : 32'h0, 32'(seen_lane));
            chk_lat(rdw[b] + 5);
            lastb = b;
        end
        apb(1'h1, ra(b, `SMC_REG_CFG), cfg(b, SMC_W32, SMC_DEV_SRAM, 1'h1, 1'h0));
        acc(1'h1, a, ~d, 4'hF);
        chk("protect error", 32'h1, 32'(e));
        chk_lat(2);
        apb(1'h1, ra(b, `SMC_REG_CFG), cfg(b, SMC_W32, SMC_DEV_ROM, 1'h0, 1'h0));
        acc(1'h1, a, ~d, 4'hF);
        chk("rom write error", 32'h1, 32'(e));
        for (int k = 0; k < 8; k++) begin
            if (k != 2) acc(1'h0, {3'(k), a[28:0]}, 32'h0, 4'hF);
            if (k != 2) chk("decode error", 32'h1, 32'(e));
        end
        for (int t = 0; t < 4; t++) begin
            apb(1'h1, ra(b, `SMC_REG_CFG), cfg(b, SMC_W32, smc_dev_t'(t), 1'h0, 1'h0));
            acc(1'h0, a, 32'h0, 4'hF);
            chk("type read", shadow[a[9:2]], r);
        end
        // Narrow beats all hit the same model word, so each beat returns its low lane.
        apb(1'h1, ra(b, `SMC_REG_CFG), cfg(b, SMC_W8, SMC_DEV_SRAM, 1'h0, 1'h0));
        acc(1'h0, a, 32'h0, 4'hF);
        chk_lat(4 * (rdw[b] + 2) + 3);
        chk("byte read", {4{shadow[a[9:2]][7:0]}}, r);
        apb(1'h1, ra(b, `SMC_REG_CFG), cfg(b, SMC_W16, SMC_DEV_SRAM, 1'h0, 1'h0));
        acc(1'h0, a, 32'h0, 4'hF);
        chk_lat(2 * (rdw[b] + 2) + 3);
        chk("half read", {2{shadow[a[9:2]][15:0]}}, r);
        apb(1'h1, ra(b, `SMC_REG_CFG), cfg(b, SMC_W8, SMC_DEV_BROM, 1'h0, 1'h1));
        acc(1'h0, a, 32'h0, 4'hF);
        chk_lat(rdw[b] + 2 + 3 * (wrw[b] + 2) + 3);
        chk("burst read", {4{shadow[a[9:2]][7:0]}}, r);
        complete_run();
    end
endmodule : static_mem_ctrl_tb_top

bind static_mem_ctrl smc_checker chk_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .sys_req(sys_req), .sys_addr(sys_addr), .sys_ready(sys_ready),
    .sys_err(sys_err), .bank_select_out(bank_select_out), .write_strobe_n(write_strobe_n),
    .read_strobe_n(read_strobe_n), .ext_address_out(ext_address_out), .ext_data_out(ext_data_out),
    .ext_data_oe(ext_data_oe));
